// ---- occ_top.sv ----
// on-chip oscillator control, trim protection, prescalers and clock backup
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module occ_top #(
	parameter int HALT_CYCLES = occ_pkg::EXT_HALT_CYCLES
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [4:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic [7:0] FLASH_TRIM_I,
	input wire logic EXT_OSC_I,
	input wire logic WATCH_CLK_I,
	output logic OSC_STANDBY_O,
	output logic OSC_FREQ_SEL_O,
	output logic OSC_SUPPLY_SEL_O,
	output logic [1:0] OSC_DIV_SEL_O,
	output logic [7:0] OSC_TRIM_O,
	output logic SYSCLK_EXT_O,
	output logic [12:0] PRESCALE_S_O,
	output logic [4:0] PRESCALE_W_O,
	output logic IRQ_O
);
	initial begin
		if (HALT_CYCLES < 2 || HALT_CYCLES > 65535) begin
			$error("occ_top: HALT_CYCLES out of range");
		end
		if (occ_pkg::PRE_S_STAGES != 13) begin
			$error("occ_top: system prescaler must match its port");
		end
		if (occ_pkg::PRE_W_STAGES - occ_pkg::PRE_W_FIRST != 5) begin
			$error("occ_top: watch prescaler taps must match the port");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus access decode
	logic ack;
	logic wr_en;
	logic rd_en;
	logic be0;
	logic [7:0] wbyte;
	logic wr_osc;
	logic wr_prot;
	logic wr_trim;
	logic wr_stat;

	assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
	assign wr_en = AVS_WRITE_I & ack;
	assign rd_en = AVS_READ_I & ~ack;
	assign be0 = AVS_BYTEENABLE_I[0];
	assign wbyte = AVS_WRITEDATA_I[7:0];
	assign wr_osc = wr_en & be0 & (AVS_ADDRESS_I == occ_pkg::OFS_OSC_CTRL);
	// protect register only takes whole-byte writes
	assign wr_prot = wr_en & be0 & (AVS_ADDRESS_I == occ_pkg::OFS_TRIM_PROT);
	assign wr_trim = wr_en & be0 & (AVS_ADDRESS_I == occ_pkg::OFS_TRIM_DATA);
	assign wr_stat = wr_en & be0 & (AVS_ADDRESS_I == occ_pkg::OFS_CLK_STAT);

	// one wait cycle on every access, then the answer
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ack <= 1'b0;
		end else begin
			ack <= (AVS_READ_I | AVS_WRITE_I) & ~ack;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator_control
	occ_pkg::occ_osc_ctrl_s osc;
	logic osc_standby;
	logic osc_freq;
	logic osc_supply;
	logic [1:0] osc_div;
	logic clk_state;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			osc_standby <= occ_pkg::OSC_STANDBY_RST;
			osc_freq <= occ_pkg::OSC_FREQ_RST;
			osc_supply <= occ_pkg::OSC_SUPPLY_RST;
		end else if (wr_osc) begin
			osc_standby <= wbyte[occ_pkg::OSC_STANDBY_BIT];
			osc_freq <= wbyte[occ_pkg::OSC_FREQ_BIT];
			osc_supply <= wbyte[occ_pkg::OSC_SUPPLY_BIT];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			osc_div <= occ_pkg::OSC_DIV_RST;
		end else if (wr_osc && !clk_state) begin
			osc_div <= wbyte[occ_pkg::OSC_DIV_LSB +: 2];
		end
	end

	// one driver for the whole control struct
	assign osc = {osc_standby, osc_freq, osc_supply, osc_div};

	// control outputs follow the register with no extra delay
	assign OSC_STANDBY_O = osc.standby;
	assign OSC_FREQ_SEL_O = osc.freq_sel;
	assign OSC_SUPPLY_SEL_O = osc.supply_sel;
	assign OSC_DIV_SEL_O = osc.div_sel;

	////////////////////////////////////////////////////////////////////////
	// trim_write_protect
	occ_pkg::occ_prot_s prot;
	logic prot_info_we;
	logic prot_lock;
	logic prot_trim_we;
	logic prot_ok;

	assign prot_ok = wr_prot & ~wbyte[occ_pkg::PROT_INHIBIT_BIT];

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			prot_info_we <= 1'b0;
		end else if (prot_ok) begin
			prot_info_we <= wbyte[occ_pkg::PROT_INFO_WE_BIT];
		end
	end

	// lock-down is sticky until reset; zero writes do nothing
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			prot_lock <= 1'b0;
		end else if (prot_ok && prot_info_we &&
				wbyte[occ_pkg::PROT_LOCK_BIT]) begin
			prot_lock <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			prot_trim_we <= 1'b0;
		end else if (prot_ok && prot_info_we) begin
			prot_trim_we <= wbyte[occ_pkg::PROT_TRIM_WE_BIT];
		end
	end

	// one driver for the whole protect struct
	assign prot = {prot_info_we, prot_lock, prot_trim_we};

	////////////////////////////////////////////////////////////////////////
	// trim_data_register, loaded from flash after reset release
	logic [7:0] trim;
	logic trim_loaded;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			trim <= occ_pkg::TRIM_RST;
			trim_loaded <= 1'b0;
		end else if (!trim_loaded) begin
			trim <= FLASH_TRIM_I;
			trim_loaded <= 1'b1;
		end else if (wr_trim && !prot.lock_down && prot.trim_we) begin
			trim <= wbyte;
		end
	end

	// signed trim code drives the oscillator directly
	assign OSC_TRIM_O = trim;

	////////////////////////////////////////////////////////////////////////
	// external oscillator halt detection
	logic [2:0] ext_sync;
	logic [15:0] quiet_cnt;
	logic ext_halted;

	// ext_sync[0] feeds only ext_sync[1]
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ext_sync <= 3'h0;
		end else begin
			ext_sync <= {ext_sync[1:0], EXT_OSC_I};
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			quiet_cnt <= 16'h0000;
			ext_halted <= 1'b0;
		end else if (ext_sync[2] != ext_sync[1]) begin
			quiet_cnt <= 16'h0000;
			ext_halted <= 1'b0;
		end else if (quiet_cnt == 16'(HALT_CYCLES - 1)) begin
			ext_halted <= 1'b1;
		end else begin
			quiet_cnt <= quiet_cnt + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock_control_status: source choice, backup and fallback event
	logic sel_ext;
	logic backup_en;
	logic fallback_flag;
	logic irq_en;
	logic fallback;

	assign fallback = sel_ext & backup_en & ext_halted;
	assign clk_state = sel_ext;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sel_ext <= 1'b0;
		end else if (fallback) begin
			sel_ext <= 1'b0;
		end else if (wr_stat) begin
			sel_ext <= wbyte[occ_pkg::STAT_SEL_EXT_BIT];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			backup_en <= 1'b0;
		end else if (wr_stat) begin
			backup_en <= wbyte[occ_pkg::STAT_BACKUP_BIT];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			irq_en <= 1'b0;
		end else if (wr_stat) begin
			irq_en <= wbyte[occ_pkg::STAT_IRQ_EN_BIT];
		end
	end

	// sticky event, write one to clear; a new event wins over the clear
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			fallback_flag <= 1'b0;
		end else if (fallback) begin
			fallback_flag <= 1'b1;
		end else if (wr_stat && wbyte[occ_pkg::STAT_FALLBACK_BIT]) begin
			fallback_flag <= 1'b0;
		end
	end

	assign SYSCLK_EXT_O = sel_ext;
	assign IRQ_O = fallback_flag & irq_en;

	////////////////////////////////////////////////////////////////////////
	// prescalers
	logic [2:0] watch_sync;
	logic watch_rise;
	logic [6:0] w_taps;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			watch_sync <= 3'h0;
		end else begin
			watch_sync <= {watch_sync[1:0], WATCH_CLK_I};
		end
	end

	assign watch_rise = watch_sync[1] & ~watch_sync[2];

	// bit k is the system clock divided by 2^(k+1)
	occ_prescaler #(
		.STAGES(occ_pkg::PRE_S_STAGES)
	) u_pre_s (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.count_i(1'b1),
		.taps_o(PRESCALE_S_O)
	);

	// counts rising watch clock edges; bits 2..6 give divide 8..128
	occ_prescaler #(
		.STAGES(occ_pkg::PRE_W_STAGES)
	) u_pre_w (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.count_i(watch_rise),
		.taps_o(w_taps)
	);

	assign PRESCALE_W_O = w_taps[occ_pkg::PRE_W_STAGES-1:occ_pkg::PRE_W_FIRST];

	////////////////////////////////////////////////////////////////////////
	// read back
	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = 8'h00;
		case (AVS_ADDRESS_I)
			occ_pkg::OFS_OSC_CTRL: begin
				rd_byte = {osc.standby, osc.freq_sel, osc.supply_sel,
					occ_pkg::OSC_RSVD_VAL, osc.div_sel};
			end
			occ_pkg::OFS_TRIM_PROT: begin
				rd_byte = {occ_pkg::PROT_INHIBIT_READ, prot.info_we,
					prot.lock_down, prot.trim_we,
					occ_pkg::PROT_RSVD_VAL};
			end
			occ_pkg::OFS_TRIM_DATA: begin
				rd_byte = trim;
			end
			occ_pkg::OFS_CLK_STAT: begin
				rd_byte = {2'h0, ext_halted, irq_en, fallback_flag,
					backup_en, sel_ext, clk_state};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			AVS_READDATA_O <= 32'h0000_0000;
		end else if (rd_en) begin
			AVS_READDATA_O <= {24'h00_0000, rd_byte};
		end
	end
endmodule

// ---- occ_pkg.sv ----
// shared constants and types for the on-chip oscillator control block
package occ_pkg;
	////////////////////////////////////////////////////////////////////////
	// register byte offsets on the avalon bus
	localparam logic [4:0] OFS_OSC_CTRL = 5'h00;
	localparam logic [4:0] OFS_TRIM_PROT = 5'h04;
	localparam logic [4:0] OFS_TRIM_DATA = 5'h08;
	localparam logic [4:0] OFS_CLK_STAT = 5'h0c;
	////////////////////////////////////////////////////////////////////////
	// oscillator_control fields
	localparam int OSC_STANDBY_BIT = 7;
	localparam int OSC_FREQ_BIT = 6;
	localparam int OSC_SUPPLY_BIT = 5;
	localparam int OSC_DIV_LSB = 0;
	localparam logic OSC_STANDBY_RST = 1'b0;
	localparam logic OSC_FREQ_RST = 1'b1;
	localparam logic OSC_SUPPLY_RST = 1'b0;
	localparam logic [1:0] OSC_DIV_RST = 2'h2;
	localparam logic [2:0] OSC_RSVD_VAL = 3'h0;
	////////////////////////////////////////////////////////////////////////
	// trim_write_protect fields
	localparam int PROT_INHIBIT_BIT = 7;
	localparam int PROT_INFO_WE_BIT = 6;
	localparam int PROT_LOCK_BIT = 5;
	localparam int PROT_TRIM_WE_BIT = 4;
	localparam logic [3:0] PROT_RSVD_VAL = 4'hf;
	localparam logic PROT_INHIBIT_READ = 1'b1;
	////////////////////////////////////////////////////////////////////////
	// clock_control_status fields
	localparam int STAT_STATE_BIT = 0;
	localparam int STAT_SEL_EXT_BIT = 1;
	localparam int STAT_BACKUP_BIT = 2;
	localparam int STAT_FALLBACK_BIT = 3;
	localparam int STAT_IRQ_EN_BIT = 4;
	localparam int STAT_HALT_BIT = 5;
	////////////////////////////////////////////////////////////////////////
	// prescaler ranges and external oscillator halt timing
	localparam int PRE_S_STAGES = 13;
	localparam int PRE_W_STAGES = 7;
	localparam int PRE_W_FIRST = 2;
	localparam int CLK_MHZ = 250;
	localparam int EXT_HALT_NS = 1000;
	localparam int EXT_HALT_CYCLES = (EXT_HALT_NS * CLK_MHZ) / 1000;
	localparam logic [7:0] TRIM_RST = 8'h00;
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic standby;
		logic freq_sel;
		logic supply_sel;
		logic [1:0] div_sel;
	} occ_osc_ctrl_s;
	typedef struct packed {
		logic info_we;
		logic lock_down;
		logic trim_we;
	} occ_prot_s;
endpackage

// ---- occ_prescaler.sv ----
// binary prescaler that advances on each cycle with count_i high; its bits are the divided clocks
`timescale 1ns/1ps
module occ_prescaler #(
	parameter int STAGES = 13
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic count_i,
	output logic [STAGES-1:0] taps_o
);
	initial begin
		if (STAGES < 1 || STAGES > 16) begin
			$error("occ_prescaler: STAGES out of range");
		end
	end

	// bit k toggles at input rate / 2^k, so it is the input divided by 2^(k+1)
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			taps_o <= '0;
		end else if (count_i) begin
			taps_o <= taps_o + {{(STAGES-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ---- occ_assertions.sv ----
// bus handshake and register output checks for the oscillator control block
`timescale 1ns/1ps
module occ_assertions (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [4:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic OSC_STANDBY_O,
	input wire logic OSC_FREQ_SEL_O,
	input wire logic OSC_SUPPLY_SEL_O,
	input wire logic [1:0] OSC_DIV_SEL_O,
	input wire logic [7:0] OSC_TRIM_O,
	input wire logic SYSCLK_EXT_O,
	input wire logic IRQ_O
);
	logic tw;
	logic tr;
	logic [4:0] a;
	assign a = AVS_ADDRESS_I;
	assign tw = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
	assign tr = AVS_READ_I && !AVS_WAITREQUEST_O;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_first;
		(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
	endsequence
	sequence s_ack;
		!AVS_WAITREQUEST_O;
	endsequence
	property p_ack;
		s_first |=> s_ack;
	endproperty
	a_ack: assert property (p_ack)
		else $error("no ack after request");
	property p_rd_osc;
		tr && a == occ_pkg::OFS_OSC_CTRL |->
			AVS_READDATA_O[31:8] == 24'h0 && AVS_READDATA_O[4:2] == 3'h0;
	endproperty
	a_rd_osc: assert property (p_rd_osc)
		else $error("ctrl reserved bits");
	property p_rd_prot;
		tr && a == occ_pkg::OFS_TRIM_PROT |->
			AVS_READDATA_O[7] && AVS_READDATA_O[3:0] == 4'hf;
	endproperty
	a_rd_prot: assert property (p_rd_prot)
		else $error("protect fixed bits");
	// the flash load in the first cycle after reset is not a bus write
	property p_trim;
		$changed(OSC_TRIM_O) && $past(RST_N_I, 2) |->
			$past(tw && a == occ_pkg::OFS_TRIM_DATA);
	endproperty
	a_trim: assert property (p_trim)
		else $error("trim changed unasked");
	property p_div_hold;
		tw && a == occ_pkg::OFS_OSC_CTRL && SYSCLK_EXT_O |=>
			$stable(OSC_DIV_SEL_O);
	endproperty
	a_div_hold: assert property (p_div_hold)
		else $error("divider not held");
	property p_div_new;
		tw && a == occ_pkg::OFS_OSC_CTRL && !SYSCLK_EXT_O |=>
			OSC_DIV_SEL_O == $past(AVS_WRITEDATA_I[1:0]);
	endproperty
	a_div_new: assert property (p_div_new)
		else $error("divider not applied");
	property p_ctrl;
		tw && a == occ_pkg::OFS_OSC_CTRL |=>
			{OSC_STANDBY_O, OSC_FREQ_SEL_O, OSC_SUPPLY_SEL_O}
			== $past(AVS_WRITEDATA_I[7:5]);
	endproperty
	a_ctrl: assert property (p_ctrl)
		else $error("control bits wrong");
	property p_irq;
		$rose(IRQ_O) |->
			$fell(SYSCLK_EXT_O) || $past(tw && a == occ_pkg::OFS_CLK_STAT);
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq without fallback");
endmodule

// ---- occ_tb_top.sv ----
// testbench for the oscillator control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module occ_tb_top;
	localparam logic [4:0] A_OSC = occ_pkg::OFS_OSC_CTRL;
	localparam logic [4:0] A_PRO = occ_pkg::OFS_TRIM_PROT;
	localparam logic [4:0] A_TRM = occ_pkg::OFS_TRIM_DATA;
	localparam logic [4:0] A_STA = occ_pkg::OFS_CLK_STAT;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, ext = 0, wclk = 0, ext_run = 1;
	logic [4:0] adr = 0;
	logic [3:0] be = 4'hf, wdiv = 4'h0;
	logic [31:0] wd = 0, rdat;
	logic [7:0] ftrim = 8'ha5, trim;
	logic wreq, stby, osc_freq_select, ssel, sext, irq;
	logic [1:0] div;
	logic [12:0] ps;
	logic [4:0] pw;
	int miscompares = 0, n_tests = 0;
	always #2 clk = ~clk;
	// watch clock of 20 system cycles, driven on the rising edge
	always @(posedge clk) begin
		wdiv <= (wdiv == 4'h9) ? 4'h0 : wdiv + 4'h1;
		if (wdiv == 4'h9) wclk <= ~wclk;
	end
	always @(posedge clk) if (ext_run) ext <= ~ext;
	occ_top #(.HALT_CYCLES(8)) u_occ_top (.CLK_I(clk), .RST_N_I(rst_n),
		.AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
		.AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
		.AVS_WAITREQUEST_O(wreq), .FLASH_TRIM_I(ftrim), .EXT_OSC_I(ext),
		.WATCH_CLK_I(wclk), .OSC_STANDBY_O(stby), .OSC_FREQ_SEL_O(osc_freq_select),
		.OSC_SUPPLY_SEL_O(ssel), .OSC_DIV_SEL_O(div), .OSC_TRIM_O(trim),
		.SYSCLK_EXT_O(sext), .PRESCALE_S_O(ps), .PRESCALE_W_O(pw), .IRQ_O(irq));
	task conclude;
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// request held until the rising edge that samples waitrequest low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] m, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= {24'h0, d};
		be <= m;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (n >= 50) miscompares++;
		q = rdat[7:0];
		wr <= 0;
		rd <= 0;
		@(negedge clk);
	endtask
	task automatic w8m(input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] m);
		logic [7:0] q;
		bus(1'b1, a, d, m, q);
	endtask
	task automatic w8(input logic [4:0] a, input logic [7:0] d);
		w8m(a, d, 4'hf);
	endtask
	task automatic r8(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h0, 4'hf, q);
		`CHK(q, e)
	endtask
	task automatic do_reset(input logic [7:0] f);
		@(posedge clk);
		rst_n <= 0;
		ftrim <= f;
		repeat (10) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(negedge clk);
	endtask
	task automatic t_ctrl;
		r8(A_OSC, 8'h42);
		`CHK(trim, 8'ha5)
		w8(A_OSC, 8'hff);
		r8(A_OSC, 8'he3);
		`CHK({stby, osc_freq_select, ssel}, 3'h7)
		for (int i = 0; i < 4; i++) begin
			w8(A_OSC, i[7:0]);
			`CHK({stby, osc_freq_select, ssel, div}, i[4:0])
		end
		w8(A_STA, 8'h02);
		r8(A_STA, 8'h03);
		w8(A_OSC, 8'h01);
		`CHK(div, 2'h3)
		w8(A_STA, 8'h00);
		w8(A_OSC, 8'h01);
		`CHK(div, 2'h1)
		r8(5'h10, 8'h00);
	endtask
	task automatic t_prot;
		w8(A_TRM, 8'h3c);
		`CHK(trim, 8'ha5)
		w8m(A_PRO, 8'h40, 4'he);
		r8(A_PRO, 8'h8f);
		w8(A_PRO, 8'hc0);
		r8(A_PRO, 8'h8f);
		w8(A_PRO, 8'h50);
		r8(A_PRO, 8'hcf);
		w8(A_PRO, 8'h10);
		r8(A_PRO, 8'h9f);
		w8(A_TRM, 8'h3c);
		`CHK(trim, 8'h3c)
		w8(A_PRO, 8'h20);
		r8(A_PRO, 8'h9f);
		w8(A_PRO, 8'h40);
		w8(A_PRO, 8'h60);
		r8(A_PRO, 8'hef);
		w8(A_PRO, 8'h50);
		r8(A_PRO, 8'hff);
		w8(A_TRM, 8'h11);
		`CHK(trim, 8'h3c)
		w8(A_PRO, 8'h00);
		r8(A_PRO, 8'haf);
		do_reset(8'h80);
		r8(A_PRO, 8'h8f);
		`CHK(trim, 8'h80)
	endtask
	task automatic t_halt;
		int n;
		n = 0;
		w8(A_STA, 8'h16);
		`CHK(sext, 1'b1)
		ext_run = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sext !== 1'b0 && n < 100);
		`CHK(sext, 1'b0)
		`CHK(irq, 1'b1)
		r8(A_STA, 8'h3c);
		w8(A_STA, 8'h18);
		`CHK(irq, 1'b0)
		w8(A_STA, 8'h12);
		repeat (20) @(negedge clk);
		`CHK(sext, 1'b1)
		`CHK(irq, 1'b0)
		w8(A_STA, 8'h00);
		ext_run = 1;
	endtask
	task automatic t_pre;
		logic [12:0] s;
		logic [4:0] w;
		s = ps;
		w = pw;
		@(negedge clk);
		`CHK(ps, s + 13'h1)
		repeat (399) @(negedge clk);
		`CHK(pw, w + 5'h5)
	endtask
	initial begin
		do_reset(8'ha5);
		t_ctrl;
		t_prot;
		t_halt;
		t_pre;
		conclude;
	end
	initial begin
		#200000;
		miscompares++;
		conclude;
	end
endmodule
bind occ_top occ_assertions u_occ_assertions (.CLK_I, .RST_N_I,
	.AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I,
	.AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .OSC_STANDBY_O,
	.OSC_FREQ_SEL_O, .OSC_SUPPLY_SEL_O, .OSC_DIV_SEL_O, .OSC_TRIM_O,
	.SYSCLK_EXT_O, .IRQ_O);
